/* hw/ebp_pkg.sv */
package ebp_pkg;

  // Register addresses on the internal peripheral bus
  localparam logic [31:0] OFS_LOW_DATA = 32'hfffff008;
  localparam logic [31:0] OFS_HIGH_DATA = 32'hfffff00a;
  localparam logic [31:0] OFS_UP_DATA = 32'hfffff00c;
  localparam logic [31:0] OFS_ANALOG_DATA = 32'h0fffff0e;
  localparam logic [31:0] OFS_CTL_DATA = 32'hfffff012;
  localparam logic [31:0] OFS_LOW_DIR = 32'hfffff028;
  localparam logic [31:0] OFS_HIGH_DIR = 32'hfffff02a;
  localparam logic [31:0] OFS_UP_DIR = 32'hfffff02c;
  localparam logic [31:0] OFS_CTL_DIR = 32'hfffff032;

  // Port widths
  localparam int LOW_W = 8;
  localparam int HIGH_W = 8;
  localparam int UP_W = 4;
  localparam int ANALOG_W = 8;
  localparam int CTL_W = 7;
  localparam int PIN_W = LOW_W + HIGH_W + UP_W + ANALOG_W + CTL_W;

  // Reset values and unmapped read value: direction bits come up as inputs
  localparam logic [7:0] RST_DIR8 = 8'hff;
  localparam logic [3:0] RST_UP_DIR = 4'hf;
  localparam logic [6:0] RST_CTL_DIR = 7'h7f;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Control-pin positions on the bus-control port
  localparam int CTL_LBE = 0;
  localparam int CTL_UBE = 1;
  localparam int CTL_RW = 2;
  localparam int CTL_DATA_STROBE = 3;
  localparam int CTL_ADDRESS_STROBE = 4;
  localparam int CTL_HACK = 5;
  localparam int CTL_HREQ = 6;

  // Expansion mode codes
  localparam logic [2:0] MODE_PORT = 3'h0;
  localparam logic [2:0] MODE_EXP_A = 3'h3;
  localparam logic [2:0] MODE_EXP_B = 3'h4;
  localparam logic [2:0] MODE_EXP_C = 3'h5;
  localparam logic [2:0] MODE_EXP_D = 3'h7;

  typedef struct packed {
    logic req;
    logic we;
    logic bit_op;
    logic [2:0] bit_idx;
    logic [31:0] addr;
    logic [7:0] wdata;
  } ebp_reg_req_t;

  typedef struct packed {
    logic [15:0] ad_out;
    logic ad_drive;
    logic [3:0] upper_addr;
    logic lower_byte_enable;
    logic upper_byte_enable;
    logic read_write;
    logic data_strobe;
    logic address_strobe;
    logic hold_acknowledge;
  } ebp_bus_drv_t;

endpackage

/* hw/ebp_pin_sync.sv */
`timescale 1ns/1ns
module ebp_pin_sync #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] level_nxt;

  if (W < 1) begin : g_bad_w
    $error("ebp_pin_sync: width must be at least 1");
  end

  // A change is accepted only once the second and third stages agree
  assign level_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_r);
  assign o_level = level_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end else begin
      s1_r <= i_pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

endmodule // ebp_pin_sync

/* hw/ebp_port_mux.sv */
`timescale 1ns/1ns
// Summary of operation
// - Every pin of the general ports has its own direction bit.
// - Direction registers take whole-byte and single-bit reads and writes.
// - The low address/data port is plain I/O in code zero and carries bus lines 0-7 in bus codes.
// - The high address/data port is plain I/O in code zero and carries bus lines 8-15 in bus codes.
// - The upper-address port has four pins; byte writes drop the top nibble, reads give no data there.
// - The upper-address port carries lines 16-17 or 16-19 by code, and is plain I/O in code zero.
// - The analog-shared port is eight input-only pins with no direction control.
// - Reading the analog-shared port returns the pin states; analog-used pins read undefined.
// - No digital/analog selector exists; both paths stay on every pin.
// - The bus-control port has seven pins; byte writes drop bit 7, reads give no data there.
// - In bus codes, control pins 0-4 drive byte enables, read/write, data and address strobes.
// - A separate bit turns control pins 5 and 6 into hold acknowledge out and hold request in.
// - Bit 7 of the bus-control direction register ignores writes and reads as zero.
module ebp_port_mux
  import ebp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire ebp_reg_req_t i_reg,
  output logic [7:0] o_rdata,
  output logic o_ack,
  input wire logic [2:0] i_expansion_code,
  input wire logic i_bus_hold_pin_select,
  input wire ebp_bus_drv_t i_bus,
  output logic [15:0] o_bus_ad_in,
  output logic o_hold_request,
  input wire logic [7:0] i_low_pins,
  output logic [7:0] o_low_out,
  output logic [7:0] o_low_oe_n,
  input wire logic [7:0] i_high_pins,
  output logic [7:0] o_high_out,
  output logic [7:0] o_high_oe_n,
  input wire logic [3:0] i_up_pins,
  output logic [3:0] o_up_out,
  output logic [3:0] o_up_oe_n,
  input wire logic [7:0] i_analog_pins,
  input wire logic [6:0] i_ctl_pins,
  output logic [6:0] o_ctl_out,
  output logic [6:0] o_ctl_oe_n
);

  logic [7:0] lat_low_r;
  logic [7:0] lat_high_r;
  logic [3:0] lat_up_r;
  logic [6:0] lat_ctl_r;
  logic [7:0] dir_low_r;
  logic [7:0] dir_high_r;
  logic [3:0] dir_up_r;
  logic [6:0] dir_ctl_r;
  logic [7:0] rdata_r;
  logic ack_r;
  logic hold_req_r;
  logic [7:0] low_out_r;
  logic [7:0] low_oe_n_r;
  logic [7:0] high_out_r;
  logic [7:0] high_oe_n_r;
  logic [3:0] up_out_r;
  logic [3:0] up_oe_n_r;
  logic [6:0] ctl_out_r;
  logic [6:0] ctl_oe_n_r;
  logic [PIN_W-1:0] pin_lvl;

  ebp_pin_sync #(.W(PIN_W)) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pins({i_ctl_pins, i_analog_pins, i_up_pins, i_high_pins, i_low_pins}),
    .o_level(pin_lvl)
  );

  wire [7:0] lvl_low = pin_lvl[7:0];
  wire [7:0] lvl_high = pin_lvl[15:8];
  wire [3:0] lvl_up = pin_lvl[19:16];
  wire [7:0] lvl_analog = pin_lvl[27:20];
  wire [6:0] lvl_ctl = pin_lvl[34:28];

  // Register access decode
  wire wr = i_reg.req & i_reg.we;
  wire rd = i_reg.req & ~i_reg.we;
  wire sel_low = i_reg.addr == OFS_LOW_DATA;
  wire sel_high = i_reg.addr == OFS_HIGH_DATA;
  wire sel_up = i_reg.addr == OFS_UP_DATA;
  wire sel_analog = i_reg.addr == OFS_ANALOG_DATA;
  wire sel_ctl = i_reg.addr == OFS_CTL_DATA;
  wire sel_dlow = i_reg.addr == OFS_LOW_DIR;
  wire sel_dhigh = i_reg.addr == OFS_HIGH_DIR;
  wire sel_dup = i_reg.addr == OFS_UP_DIR;
  wire sel_dctl = i_reg.addr == OFS_CTL_DIR;

  // Byte access touches all lanes, bit access only the indexed one
  wire [7:0] wr_mask = i_reg.bit_op ? (8'h01 << i_reg.bit_idx) : 8'hff;
  wire [7:0] wr_val = i_reg.bit_op ? {8{i_reg.wdata[0]}} : i_reg.wdata;

  function automatic logic [7:0] merge(input logic [7:0] old);
    merge = (old & ~wr_mask) | (wr_val & wr_mask);
  endfunction

  // Unused upper bits of narrow registers are padded as zero before merging
  wire [7:0] nxt_lat_up = merge({4'h0, lat_up_r});
  wire [7:0] nxt_lat_ctl = merge({1'b0, lat_ctl_r});
  wire [7:0] nxt_dir_up = merge({4'h0, dir_up_r});
  wire [7:0] nxt_dir_ctl = merge({1'b0, dir_ctl_r});

  // Port data reads show the pin in input mode and the latch in output mode
  wire [7:0] rd_low = (dir_low_r & lvl_low) | (~dir_low_r & lat_low_r);
  wire [7:0] rd_high = (dir_high_r & lvl_high) | (~dir_high_r & lat_high_r);
  wire [3:0] rd_up = (dir_up_r & lvl_up) | (~dir_up_r & lat_up_r);
  wire [6:0] rd_ctl = (dir_ctl_r & lvl_ctl) | (~dir_ctl_r & lat_ctl_r);

  wire [7:0] rd_byte =
    sel_low ? rd_low :
    sel_high ? rd_high :
    sel_up ? {4'h0, rd_up} :
    sel_analog ? lvl_analog :
    sel_ctl ? {1'b0, rd_ctl} :
    sel_dlow ? dir_low_r :
    sel_dhigh ? dir_high_r :
    sel_dup ? {4'h0, dir_up_r} :
    sel_dctl ? {1'b0, dir_ctl_r} : RD_UNMAPPED;
  wire [7:0] rd_nxt = i_reg.bit_op ? {7'h00, rd_byte[i_reg.bit_idx]} : rd_byte;

  // Expansion mode decode; reserved codes leave the pins as plain ports
  wire code_ok = (i_expansion_code == MODE_EXP_A) || (i_expansion_code == MODE_EXP_B) ||
    (i_expansion_code == MODE_EXP_C) || (i_expansion_code == MODE_EXP_D);
  wire up_full = (i_expansion_code == MODE_EXP_C) || (i_expansion_code == MODE_EXP_D);
  wire up_half = (i_expansion_code == MODE_EXP_A) || (i_expansion_code == MODE_EXP_B);
  wire hold_en = i_bus_hold_pin_select;

  wire [15:0] bus_ad = i_bus.ad_out;
  wire [3:0] bus_up = i_bus.upper_addr;
  wire [6:0] bus_ctl = {1'b0, i_bus.hold_acknowledge, i_bus.address_strobe,
    i_bus.data_strobe, i_bus.read_write, i_bus.upper_byte_enable, i_bus.lower_byte_enable};
  wire [7:0] bus_oe_n = {8{~i_bus.ad_drive}};

  wire [3:0] up_exp = up_full ? 4'hf : (up_half ? 4'h3 : 4'h0);
  wire [6:0] ctl_exp = {hold_en, hold_en, {5{code_ok}}};
  wire [6:0] ctl_in_only = {hold_en, 6'h00};

  wire [7:0] low_out_nxt = code_ok ? bus_ad[7:0] : lat_low_r;
  wire [7:0] low_oe_n_nxt = code_ok ? bus_oe_n : dir_low_r;
  wire [7:0] high_out_nxt = code_ok ? bus_ad[15:8] : lat_high_r;
  wire [7:0] high_oe_n_nxt = code_ok ? bus_oe_n : dir_high_r;
  wire [3:0] up_out_nxt = (up_exp & bus_up) | (~up_exp & lat_up_r);
  wire [3:0] up_oe_n_nxt = ~up_exp & dir_up_r;
  wire [6:0] ctl_out_nxt = (ctl_exp & bus_ctl) | (~ctl_exp & lat_ctl_r);
  wire [6:0] ctl_oe_n_nxt = ctl_in_only | (~ctl_exp & dir_ctl_r);
  wire hold_req_nxt = hold_en & lvl_ctl[CTL_HREQ];

  // Software registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lat_low_r <= RST_LATCH;
      lat_high_r <= RST_LATCH;
      lat_up_r <= RST_LATCH[3:0];
      lat_ctl_r <= RST_LATCH[6:0];
      dir_low_r <= RST_DIR8;
      dir_high_r <= RST_DIR8;
      dir_up_r <= RST_UP_DIR;
      dir_ctl_r <= RST_CTL_DIR;
    end else begin
      if (wr && sel_low) lat_low_r <= merge(lat_low_r);
      if (wr && sel_high) lat_high_r <= merge(lat_high_r);
      if (wr && sel_up) lat_up_r <= nxt_lat_up[3:0];
      if (wr && sel_ctl) lat_ctl_r <= nxt_lat_ctl[6:0];
      if (wr && sel_dlow) dir_low_r <= merge(dir_low_r);
      if (wr && sel_dhigh) dir_high_r <= merge(dir_high_r);
      if (wr && sel_dup) dir_up_r <= nxt_dir_up[3:0];
      if (wr && sel_dctl) dir_ctl_r <= nxt_dir_ctl[6:0];
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
    end else begin
      ack_r <= i_reg.req;
      if (rd) rdata_r <= rd_nxt;
    end
  end

  // Pin drivers: bus duty overrides latch and direction
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_out_r <= 8'h00;
      low_oe_n_r <= 8'hff;
      high_out_r <= 8'h00;
      high_oe_n_r <= 8'hff;
      up_out_r <= 4'h0;
      up_oe_n_r <= 4'hf;
      ctl_out_r <= 7'h00;
      ctl_oe_n_r <= 7'h7f;
      hold_req_r <= 1'b0;
    end else begin
      low_out_r <= low_out_nxt;
      low_oe_n_r <= low_oe_n_nxt;
      high_out_r <= high_out_nxt;
      high_oe_n_r <= high_oe_n_nxt;
      up_out_r <= up_out_nxt;
      up_oe_n_r <= up_oe_n_nxt;
      ctl_out_r <= ctl_out_nxt;
      ctl_oe_n_r <= ctl_oe_n_nxt;
      hold_req_r <= hold_req_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_ack = ack_r;
  assign o_bus_ad_in = {lvl_high, lvl_low};
  assign o_hold_request = hold_req_r;
  assign o_low_out = low_out_r;
  assign o_low_oe_n = low_oe_n_r;
  assign o_high_out = high_out_r;
  assign o_high_oe_n = high_oe_n_r;
  assign o_up_out = up_out_r;
  assign o_up_oe_n = up_oe_n_r;
  assign o_ctl_out = ctl_out_r;
  assign o_ctl_oe_n = ctl_oe_n_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence analog_read_s;
    rd && sel_analog && !i_reg.bit_op;
  endsequence

  low_bus_duty_a: assert property (code_ok |=>
    o_low_out == $past(bus_ad[7:0]) && o_low_oe_n == $past(bus_oe_n))
    else $error("low port does not follow the bus in expansion mode");
  high_port_mode_a: assert property (i_expansion_code == MODE_PORT |=>
    o_high_out == $past(lat_high_r) && o_high_oe_n == $past(dir_high_r))
    else $error("high port does not follow latch and direction in port mode");
  up_half_mode_a: assert property (up_half |=>
    o_up_out[1:0] == $past(bus_up[1:0]) && o_up_oe_n[1:0] == 2'h0 &&
    o_up_oe_n[3:2] == $past(dir_up_r[3:2]))
    else $error("upper port wrong in two-line address mode");
  up_byte_write_a: assert property (wr && sel_up && !i_reg.bit_op |=>
    lat_up_r == $past(i_reg.wdata[3:0]))
    else $error("upper port latch not loaded from low nibble");
  ctl_dir_read_a: assert property (rd && sel_dctl && !i_reg.bit_op |=>
    o_ack && o_rdata == {1'b0, $past(dir_ctl_r)})
    else $error("bus-control direction read wrong");
  hold_pin_duty_a: assert property (hold_en |=>
    o_ctl_oe_n[CTL_HREQ] && !o_ctl_oe_n[CTL_HACK] &&
    o_ctl_out[CTL_HACK] == $past(i_bus.hold_acknowledge))
    else $error("hold pins not on bus-hold duty");
  ctl_bus_duty_a: assert property (code_ok && !hold_en |=>
    o_ctl_out[4:0] == $past(bus_ctl[4:0]) && o_ctl_oe_n[4:0] == 5'h00 &&
    o_ctl_out[6:5] == $past(lat_ctl_r[6:5]))
    else $error("bus-control pins wrong in expansion mode");
  dir_bit_write_a: assert property (wr && sel_dlow && i_reg.bit_op |=>
    (dir_low_r & ~$past(wr_mask)) == ($past(dir_low_r) & ~$past(wr_mask)) &&
    (dir_low_r & $past(wr_mask)) == ($past(wr_mask) & {8{$past(i_reg.wdata[0])}}))
    else $error("bit write to direction touched other bits");
  input_dir_a: assert property (!code_ok && dir_low_r[0] |=> o_low_oe_n[0])
    else $error("input-mode pin is being driven");
  analog_read_a: assert property (analog_read_s |=> o_ack &&
    o_rdata == $past(lvl_analog))
    else $error("analog-shared port read does not show pin levels");

  sequence port_mode_s;
    !code_ok && !hold_en;
  endsequence

  sequence ctl_byte_write_s;
    wr && sel_ctl && !i_reg.bit_op;
  endsequence

  low_port_mode_a: assert property (i_expansion_code == MODE_PORT |=>
    o_low_out == $past(lat_low_r) && o_low_oe_n == $past(dir_low_r))
    else $error("low port does not follow latch and direction in port mode");
  high_bus_duty_a: assert property (code_ok |=>
    o_high_out == $past(bus_ad[15:8]) && o_high_oe_n == $past(bus_oe_n))
    else $error("high port does not follow the bus in expansion mode");
  up_full_mode_a: assert property (up_full |=>
    o_up_out == $past(bus_up) && o_up_oe_n == 4'h0)
    else $error("upper port wrong in four-line address mode");
  up_port_mode_a: assert property (!up_full && !up_half |=>
    o_up_out == $past(lat_up_r) && o_up_oe_n == $past(dir_up_r))
    else $error("upper port does not follow latch and direction in port mode");
  up_byte_read_a: assert property (rd && sel_up && !i_reg.bit_op |=>
    o_rdata[7:4] == 4'h0 && o_rdata[3:0] == $past(rd_up))
    else $error("upper port read shows data above its four pins");
  ctl_byte_write_a: assert property (ctl_byte_write_s |=>
    lat_ctl_r == $past(i_reg.wdata[6:0]))
    else $error("bus-control latch not loaded from the low seven bits");
  ctl_dir_write_a: assert property (wr && sel_dctl && !i_reg.bit_op |=>
    dir_ctl_r == $past(i_reg.wdata[6:0]))
    else $error("bus-control direction write took the top bit");
  ctl_port_mode_a: assert property (port_mode_s |=>
    o_ctl_out == $past(lat_ctl_r) && o_ctl_oe_n == $past(dir_ctl_r))
    else $error("bus-control pins do not follow latch and direction in port mode");
  hold_req_off_a: assert property (!hold_en |=> !o_hold_request)
    else $error("hold request seen while hold pins are plain port pins");
  reg_ack_a: assert property (i_reg.req |=> o_ack)
    else $error("register access not acknowledged after one cycle");
  bit_read_a: assert property (rd && i_reg.bit_op |=>
    o_rdata == {7'h00, $past(rd_byte[i_reg.bit_idx])})
    else $error("bit read does not return the addressed bit alone");

endmodule // ebp_port_mux

/* bench/ebp_ext_mem_model.sv */
`timescale 1ns/1ns
module ebp_ext_mem_model (
  input wire logic [7:0] i_low_out,
  input wire logic [7:0] i_low_oe_n,
  input wire logic [7:0] i_high_out,
  input wire logic [7:0] i_high_oe_n,
  input wire logic [3:0] i_up_out,
  input wire logic [3:0] i_up_oe_n,
  input wire logic [6:0] i_ctl_out,
  input wire logic [6:0] i_ctl_oe_n,
  input wire logic i_mem_drive,
  input wire logic [15:0] i_mem_data,
  input wire logic i_hold_req,
  output logic [7:0] o_low_pins,
  output logic [7:0] o_high_pins,
  output logic [3:0] o_up_pins,
  output logic [6:0] o_ctl_pins
);
  // Released lines take the memory data or the hold request where those drive, else the board pull-ups, never the last value
  wire logic [15:0] ad_far = i_mem_drive ? i_mem_data : 16'hffff;
  wire logic [6:0] ctl_far = {i_hold_req, 6'h3f};
  assign o_low_pins = (i_low_oe_n & ad_far[7:0]) | (~i_low_oe_n & i_low_out);
  assign o_high_pins = (i_high_oe_n & ad_far[15:8]) | (~i_high_oe_n & i_high_out);
  assign o_up_pins = (i_up_oe_n & 4'hf) | (~i_up_oe_n & i_up_out);
  assign o_ctl_pins = (i_ctl_oe_n & ctl_far) | (~i_ctl_oe_n & i_ctl_out);
endmodule // ebp_ext_mem_model

/* bench/expansion_bus_port_mux_bench.sv */
`timescale 1ns/1ns
module expansion_bus_port_mux_bench
  import ebp_pkg::*;
;
  logic i_clk, i_resetn, ack, hsel, hreq, mem_drv, hold_in, mc;
  ebp_reg_req_t reg_req;
  ebp_bus_drv_t bus;
  logic [2:0] code;
  logic [7:0] rdata, low_p, low_o, low_oe, high_p, high_o, high_oe, ana, d, v, me;
  logic [3:0] up_p, up_o, up_oe, m;
  logic [6:0] ctl_p, ctl_o, ctl_oe;
  logic [15:0] ad_in, mem_data, w;
  logic [31:0] rnd;
  logic [2:0] codes [4] = '{MODE_EXP_A, MODE_EXP_B, MODE_EXP_C, MODE_EXP_D};
  int err_count, n_checks, seed;
  logic [7:0] exp_q [$];
  bit chk_q [$];

  ebp_port_mux dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg(reg_req), .o_rdata(rdata),
    .o_ack(ack), .i_expansion_code(code), .i_bus_hold_pin_select(hsel), .i_bus(bus),
    .o_bus_ad_in(ad_in), .o_hold_request(hreq), .i_low_pins(low_p), .o_low_out(low_o),
    .o_low_oe_n(low_oe), .i_high_pins(high_p), .o_high_out(high_o), .o_high_oe_n(high_oe),
    .i_up_pins(up_p), .o_up_out(up_o), .o_up_oe_n(up_oe), .i_analog_pins(ana),
    .i_ctl_pins(ctl_p), .o_ctl_out(ctl_o), .o_ctl_oe_n(ctl_oe));

  ebp_ext_mem_model far_u (.i_low_out(low_o), .i_low_oe_n(low_oe), .i_high_out(high_o),
    .i_high_oe_n(high_oe), .i_up_out(up_o), .i_up_oe_n(up_oe), .i_ctl_out(ctl_o),
    .i_ctl_oe_n(ctl_oe), .i_mem_drive(mem_drv), .i_mem_data(mem_data), .i_hold_req(hold_in),
    .o_low_pins(low_p), .o_high_pins(high_p), .o_up_pins(up_p), .o_ctl_pins(ctl_p));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // One register access; reads leave their expected data for the monitor
  task automatic acc(input logic we, input logic bop, input logic [2:0] idx,
                     input logic [31:0] a, input logic [7:0] wd, input logic [7:0] e);
    @(negedge i_clk);
    reg_req = '{1'b1, we, bop, idx, a, wd};
    exp_q.push_back(e);
    chk_q.push_back(!we);
    @(negedge i_clk);
    reg_req.req = 1'b0;
  endtask

  always @(negedge i_clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'h1, 16'h0);
      end else begin
        me = exp_q.pop_front();
        mc = chk_q.pop_front();
        if (mc) check(rdata, me);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    stop_test();
  end

  initial begin
    seed = 75253;
    i_resetn = 1'b0;
    reg_req = '0;
    code = MODE_PORT;
    hsel = 1'b0;
    bus = '0;
    mem_drv = 1'b0;
    mem_data = '0;
    hold_in = 1'b0;
    ana = '0;
    wait_cyc(20);
    i_resetn = 1'b1;
    wait_cyc(2);
    check(low_oe, 8'hff);
    acc(0, 0, 0, OFS_LOW_DIR, 0, RST_DIR8);
    acc(0, 0, 0, OFS_UP_DIR, 0, 8'h0f);
    acc(0, 0, 0, OFS_CTL_DIR, 0, 8'h7f);
    acc(0, 0, 0, 32'hfffff0f0, 0, RD_UNMAPPED);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      v = 8'($random(seed));
      mem_data = 16'($random(seed));
      mem_drv = i[0];
      acc(1, 0, 0, OFS_LOW_DIR, d, 0);
      acc(1, 0, 0, OFS_LOW_DATA, v, 0);
      acc(1, 0, 0, OFS_HIGH_DIR, ~d, 0);
      acc(1, 0, 0, OFS_HIGH_DATA, ~v, 0);
      wait_cyc(6);
      check(low_oe, d);
      check(low_o & ~d, v & ~d);
      check(high_oe, 8'(~d));
      check(high_o & d, 8'(~v) & d);
      w = mem_drv ? mem_data : 16'hffff;
      acc(0, 0, 0, OFS_LOW_DATA, 0, (v & ~d) | (w[7:0] & d));
      acc(0, 0, 0, OFS_HIGH_DATA, 0, (~v & d) | (w[15:8] & ~d));
      acc(1, 1, i[2:0], OFS_LOW_DIR, 8'h00, 0);
      acc(0, 1, i[2:0], OFS_LOW_DIR, 0, 8'h00);
      acc(0, 1, ~i[2:0], OFS_LOW_DIR, 0, {7'h0, d[~i[2:0]]});
    end
    acc(1, 0, 0, OFS_UP_DIR, 8'h00, 0);
    acc(1, 0, 0, OFS_UP_DATA, 8'h5a, 0);
    acc(0, 0, 0, OFS_UP_DATA, 0, 8'h0a);
    acc(1, 0, 0, OFS_CTL_DIR, 8'h80, 0);
    acc(0, 0, 0, OFS_CTL_DIR, 0, 8'h00);
    acc(1, 0, 0, OFS_CTL_DATA, 8'hd5, 0);
    acc(0, 0, 0, OFS_CTL_DATA, 0, 8'h55);
    wait_cyc(2);
    check(up_o, 4'ha);
    check(ctl_o, 7'h55);
    acc(1, 0, 0, OFS_LOW_DIR, 8'hff, 0);
    acc(1, 0, 0, OFS_HIGH_DIR, 8'hff, 0);
    acc(1, 0, 0, OFS_UP_DIR, 8'hff, 0);
    acc(1, 0, 0, OFS_CTL_DIR, 8'hff, 0);
    foreach (codes[j]) begin
      code = codes[j];
      rnd = $random(seed);
      bus = rnd[25:0];
      bus.ad_drive = 1'b1;
      m = (code[2] & code[0]) ? 4'hf : 4'h3;
      wait_cyc(2);
      check({high_o, low_o}, bus.ad_out);
      check({high_oe, low_oe}, 16'h0000);
      check(up_oe, 4'(~m));
      check(up_o & m, bus.upper_addr & m);
      check(ctl_oe[4:0], 5'h00);
      check(ctl_o[4:0], {bus.address_strobe, bus.data_strobe, bus.read_write,
                         bus.upper_byte_enable, bus.lower_byte_enable});
      bus.ad_drive = 1'b0;
      mem_drv = 1'b1;
      mem_data = 16'($random(seed));
      wait_cyc(6);
      check(ad_in, mem_data);
    end
    code = 3'h1;
    wait_cyc(2);
    check({high_oe, low_oe}, 16'hffff);
    check({ctl_oe, up_oe}, 11'h7ff);
    hsel = 1'b1;
    bus.hold_acknowledge = 1'b1;
    hold_in = 1'b1;
    wait_cyc(7);
    check(ctl_oe[6:5], 2'b10);
    check(ctl_o[5], 1'b1);
    check(hreq, 1'b1);
    hold_in = 1'b0;
    wait_cyc(7);
    check(hreq, 1'b0);
    hsel = 1'b0;
    hold_in = 1'b1;
    wait_cyc(7);
    check(hreq, 1'b0);
    check(ctl_oe[6:5], 2'b11);
    // No conversion runs and every shared pin is used digitally
    for (int k = 0; k < 4; k++) begin
      ana = 8'($random(seed));
      wait_cyc(6);
      acc(1, 0, 0, OFS_ANALOG_DATA, ~ana, 0);
      acc(0, 0, 0, OFS_ANALOG_DATA, 0, ana);
    end
    for (int t = 0; t < 20 && exp_q.size() > 0; t++) @(negedge i_clk);
    if (exp_q.size() != 0) err_count++;
    stop_test();
  end
endmodule // expansion_bus_port_mux_bench
